// *** flh_defs.svh ***
// Constants for the fourth data line pin logic of the serial flash
// Function
// [RULE1] While paused, ignore clock and input data, float the serial output.
// [RULE2] Host starts a pause only with chip select low and clock low.
// [RULE3] Pause only suspends the interface; no deselect, reset or engine abort.
// [RULE4] Quad program data phase samples line three on each clock rise.
// [RULE5] Quad read data phase drives line three, updated on each clock fall.
// [RULE6] Quad enable clear: pin is pause or reset per third status bit 7.
// [RULE7] Quad enable set: pause and reset off, pin carries data only.
// [RULE8] Quad enable lives in the second status register, enabling quad transfers.
// [RULE9] Reset role with pin low aborts command, interface returns idle deselected.
`ifndef FLH_DEFS_SVH
`define FLH_DEFS_SVH

// Status register field positions
`define FLH_SR2_QE_BIT        1
`define FLH_SR3_HOLD_RST_BIT  7

// Reset values of the registered outputs
`define FLH_RST_IO3_VAL       1'b1
`define FLH_RST_IO3_OE        1'b0
`define FLH_RST_SO_FLOAT      1'b1
`define FLH_RST_IF_RESET      1'b1

// Synchroniser depth for pin inputs
`define FLH_SYNC_STAGES       2

`endif

// *** flh_host.sv ***
// Host controller model driving clock, select and line three
`default_nettype none
module flh_host (
  // Clock
  input  wire logic ref_clk_in,
  // Pins toward the flash
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      line_out,
  output logic      line_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    line_out = 1'b1;
    line_en_out = 1'b0;
  end
  // Clock and select settle before line moves
  task automatic drive(input logic s, input logic c, input logic l, input logic e);
    @(posedge ref_clk_in);
    sck_out <= s;
    cs_n_out <= c;
    @(posedge ref_clk_in);
    line_out <= l;
    line_en_out <= e;
  endtask : drive
endmodule : flh_host
`default_nettype wire

// *** flh_io3_logic.sv ***
// Fourth data line logic: pause, pin reset and quad data line three
`include "flh_defs.svh"
`default_nettype none

module flh_io3_logic (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  // Serial pins from the host
  input  wire logic       sck_in,
  input  wire logic       cs_n_in,
  input  wire logic       data_line_three_in,
  // Configuration from the status registers
  input  wire logic [7:0] status2_in,
  input  wire logic [7:0] status3_in,
  // Command core phase and read data
  input  wire logic       quad_write_phase_in,
  input  wire logic       quad_read_phase_in,
  input  wire logic       io3_tx_bit_in,
  // Pin drive
  output logic            data_line_three_out,
  output logic            data_line_three_oe_out,
  // To the command core
  output logic            sck_rise_out,
  output logic            sck_fall_out,
  output logic            io3_rx_bit_out,
  output logic            io3_rx_valid_out,
  output logic            so_float_out,
  output logic            pause_active_out,
  output logic            if_reset_out,
  output logic            abort_out
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [2:0] pins_sync;
  logic       sck_s;
  logic       cs_n_s;
  logic       io3_s;

  flh_sync #(
    .WIDTH (3)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   ({sck_in, cs_n_in, data_line_three_in}),
    .sync_out   (pins_sync)
  );

  assign sck_s  = pins_sync[2];
  assign cs_n_s = pins_sync[1];
  assign io3_s  = pins_sync[0];

  ////////////////////////////////////////////////////////////////////////
  // Role decode

  function automatic flh_pkg::flh_role_t flh_role_of(input logic [7:0] sr2,
                                                     input logic [7:0] sr3);
    // [RULE8] Quad enable bit
    if (sr2[`FLH_SR2_QE_BIT]) begin
      // [RULE7] Data only role
      return flh_pkg::FLH_ROLE_DATA;
    end
    // [RULE6] Pause or reset select
    if (sr3[`FLH_SR3_HOLD_RST_BIT]) begin
      return flh_pkg::FLH_ROLE_RESET;
    end
    return flh_pkg::FLH_ROLE_PAUSE;
  endfunction : flh_role_of

  // Shared by both clock edges so rise and fall can never gate differently
  function automatic logic flh_edge_pass(input logic                edge_seen,
                                         input logic                sel,
                                         input logic                pin_rst,
                                         input flh_pkg::flh_pause_t pause_now);
    return edge_seen && sel && !pin_rst && (pause_now == flh_pkg::FLH_RUN);
  endfunction : flh_edge_pass

  ////////////////////////////////////////////////////////////////////////
  // State

  flh_pkg::flh_state_t state_reg;
  flh_pkg::flh_state_t state_next;
  logic                rise;
  logic                fall;
  logic                selected;
  logic                in_reset;

  always_comb begin
    state_next          = state_reg;
    state_next.sck_prev = sck_s;
    state_next.role     = flh_role_of(status2_in, status3_in);
    state_next.abort    = 1'b0;
    state_next.rx_valid = 1'b0;
    selected            = !cs_n_s;
    rise                = sck_s && !state_reg.sck_prev;
    fall                = !sck_s && state_reg.sck_prev;
    // [RULE9] Pin reset holds interface idle
    in_reset = (state_reg.role == flh_pkg::FLH_ROLE_RESET) && !io3_s;
    unique case (state_reg.pause)
      flh_pkg::FLH_RUN: begin
        // [RULE2] Pause needs select and clock low
        if (state_reg.role == flh_pkg::FLH_ROLE_PAUSE && !io3_s && selected && !sck_s) begin
          state_next.pause = flh_pkg::FLH_PAUSED;
        end
      end
      flh_pkg::FLH_PAUSED: begin
        // Resume on line high waits for clock low so no half edge slips through
        if (state_reg.role != flh_pkg::FLH_ROLE_PAUSE || !selected || (io3_s && !sck_s)) begin
          state_next.pause = flh_pkg::FLH_RUN;
        end
      end
    endcase
    if (state_next.role != flh_pkg::FLH_ROLE_PAUSE) begin
      state_next.pause = flh_pkg::FLH_RUN;
    end
    // [RULE1] Gate clock edges while paused
    state_next.sck_rise = flh_edge_pass(rise, selected, in_reset, state_next.pause);
    state_next.sck_fall = flh_edge_pass(fall, selected, in_reset, state_next.pause);
    // [RULE1] Serial output floats while paused
    state_next.so_float = !selected || in_reset
                          || state_next.pause == flh_pkg::FLH_PAUSED;
    // [RULE3] Pause leaves select and engines alone
    state_next.if_reset = !selected || in_reset;
    // [RULE9] Abort pulse on entry to pin reset
    state_next.abort = in_reset && !state_reg.if_reset;
    // [RULE4] Capture line three on rise
    if (state_next.sck_rise && state_reg.role == flh_pkg::FLH_ROLE_DATA
        && quad_write_phase_in) begin
      state_next.rx_bit   = io3_s;
      state_next.rx_valid = 1'b1;
    end
    // [RULE5] Drive line three, update on fall
    state_next.io3_oe = selected && state_reg.role == flh_pkg::FLH_ROLE_DATA
                        && quad_read_phase_in;
    if (state_next.io3_oe && (state_next.sck_fall || !state_reg.io3_oe)) begin
      state_next.io3_val = io3_tx_bit_in;
    end else if (!state_next.io3_oe) begin
      state_next.io3_val = `FLH_RST_IO3_VAL;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_reg          <= '0;
      state_reg.sck_prev <= 1'b1;
      state_reg.role     <= flh_pkg::FLH_ROLE_PAUSE;
      state_reg.pause    <= flh_pkg::FLH_RUN;
      state_reg.io3_val  <= `FLH_RST_IO3_VAL;
      state_reg.io3_oe   <= `FLH_RST_IO3_OE;
      state_reg.so_float <= `FLH_RST_SO_FLOAT;
      state_reg.if_reset <= `FLH_RST_IF_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign data_line_three_out    = state_reg.io3_val;
  assign data_line_three_oe_out = state_reg.io3_oe;
  assign sck_rise_out           = state_reg.sck_rise;
  assign sck_fall_out           = state_reg.sck_fall;
  assign io3_rx_bit_out         = state_reg.rx_bit;
  assign io3_rx_valid_out       = state_reg.rx_valid;
  assign so_float_out           = state_reg.so_float;
  assign pause_active_out       = (state_reg.pause == flh_pkg::FLH_PAUSED);
  assign if_reset_out           = state_reg.if_reset;
  assign abort_out              = state_reg.abort;

endmodule : flh_io3_logic

`default_nettype wire

// *** flh_io3_logic_properties.sv ***
// Checker for the fourth data line pin logic
`default_nettype none
module flh_io3_chk (
  input wire logic ref_clk_in, reset_in, sck_in, cs_n_in, data_line_three_in,
  input wire logic [7:0] status2_in, status3_in,
  input wire logic quad_write_phase_in, quad_read_phase_in, io3_tx_bit_in,
  input wire logic data_line_three_out, data_line_three_oe_out, sck_rise_out,
  input wire logic sck_fall_out, io3_rx_bit_out, io3_rx_valid_out, so_float_out,
  input wire logic pause_active_out, if_reset_out, abort_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  chk_pause_float: assert property (pause_active_out |-> so_float_out)
    else $error("output driven while paused");
  chk_pause_gates: assert property (pause_active_out |-> !sck_rise_out && !io3_rx_valid_out)
    else $error("clock seen while paused");
  chk_pause_no_reset: assert property (pause_active_out |-> !if_reset_out && !abort_out)
    else $error("pause reset the interface");
  chk_quad_no_pause: assert property ($past(status2_in[1], 2) && $past(status2_in[1]) |->
    !pause_active_out && !abort_out) else $error("pause or reset in quad role");
  chk_rx_cause: assert property (io3_rx_valid_out |-> sck_rise_out &&
    $past(quad_write_phase_in) && $past(status2_in[1], 2)) else $error("stray capture");
  chk_rx_value: assert property (io3_rx_valid_out |->
    io3_rx_bit_out == $past(data_line_three_in, 3)) else $error("captured bit wrong");
  chk_read_update: assert property (sck_fall_out && data_line_three_oe_out &&
    $past(data_line_three_oe_out) |-> data_line_three_out == $past(io3_tx_bit_in))
    else $error("read bit wrong");
  chk_drive_cause: assert property (data_line_three_oe_out |->
    ($past(quad_read_phase_in) || $past(quad_read_phase_in, 2)) && $past(status2_in[1], 2))
    else $error("line driven outside quad read");
  chk_pause_role: assert property ($rose(pause_active_out) |->
    !$past(status3_in[7], 2) && !$past(status2_in[1], 2)) else $error("pause in wrong role");
  chk_abort_idle: assert property (abort_out |-> if_reset_out && so_float_out &&
    $past(status3_in[7], 2) && !$past(status2_in[1], 2)) else $error("abort wrong");
  cover property (abort_out);
  cover property ($rose(pause_active_out));
  cover property (io3_rx_valid_out && io3_rx_bit_out);
  cover property (sck_fall_out && data_line_three_oe_out);
endmodule : flh_io3_chk
bind flh_io3_logic flh_io3_chk flh_io3_chk_i (
  .ref_clk_in             (ref_clk_in),
  .reset_in               (reset_in),
  .sck_in                 (sck_in),
  .cs_n_in                (cs_n_in),
  .data_line_three_in     (data_line_three_in),
  .status2_in             (status2_in),
  .status3_in             (status3_in),
  .quad_write_phase_in    (quad_write_phase_in),
  .quad_read_phase_in     (quad_read_phase_in),
  .io3_tx_bit_in          (io3_tx_bit_in),
  .data_line_three_out    (data_line_three_out),
  .data_line_three_oe_out (data_line_three_oe_out),
  .sck_rise_out           (sck_rise_out),
  .sck_fall_out           (sck_fall_out),
  .io3_rx_bit_out         (io3_rx_bit_out),
  .io3_rx_valid_out       (io3_rx_valid_out),
  .so_float_out           (so_float_out),
  .pause_active_out       (pause_active_out),
  .if_reset_out           (if_reset_out),
  .abort_out              (abort_out)
);
`default_nettype wire

// *** flh_pkg.sv ***
// Types shared by the fourth data line pin logic
`default_nettype none

package flh_pkg;

  // Role the pin plays at a given moment
  typedef enum logic [1:0] {
    FLH_ROLE_PAUSE,
    FLH_ROLE_RESET,
    FLH_ROLE_DATA
  } flh_role_t;

  // Pause state of the serial interface
  typedef enum logic [0:0] {
    FLH_RUN,
    FLH_PAUSED
  } flh_pause_t;

  typedef struct packed {
    logic       sck_prev;
    flh_role_t  role;
    flh_pause_t pause;
    logic       io3_val;
    logic       io3_oe;
    logic       rx_bit;
    logic       rx_valid;
    logic       sck_rise;
    logic       sck_fall;
    logic       so_float;
    logic       if_reset;
    logic       abort;
  } flh_state_t;

endpackage : flh_pkg

`default_nettype wire

// *** flh_sync.sv ***
// Two-flop synchroniser for the asynchronous pin inputs
`default_nettype none

module flh_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             reset_in,
  // Pins in, synchronised copies out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // Idle pin levels: clock, chip select and line three all high
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : flh_sync

`default_nettype wire

// *** test_flh_io3_logic.sv ***
// Self-checking bench for the fourth data line pin logic
`default_nettype none
module test_flh_io3_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wph, rph, txb, sck, cs_n, hl, hen, pin;
  logic [7:0] st2, st3;
  logic o, oe, rise, fall, rxb, rxv, flt, pau, ifr, abt;
  int n_fail, check_count, r, n_edge;
  // Row: {0,quad,reset role,cs_n,sck,line,read,tx} then {pause,float,idle,oe,out}
  logic [15:0] rows [19] = '{16'h140d, 16'h0401, 16'h0019, 16'h0819, 16'h0401,
    16'h0c01, 16'h0801, 16'h0019, 16'h100d, 16'h340d, 16'h2401, 16'h200d, 16'h2401,
    16'h6001, 16'h4001, 16'h4602, 16'h4702, 16'h540d, 16'h0701};
  // Pull-up holds the pin high when nobody drives it
  assign pin = oe ? o : (hen ? hl : 1'b1);
  always #2 clk = ~clk;
  flh_host flh_host_i (.ref_clk_in(clk), .sck_out(sck), .cs_n_out(cs_n), .line_out(hl),
    .line_en_out(hen));
  flh_io3_logic flh_io3_logic_i (.ref_clk_in(clk), .reset_in(rst), .sck_in(sck),
    .cs_n_in(cs_n), .data_line_three_in(pin), .status2_in(st2), .status3_in(st3),
    .quad_write_phase_in(wph), .quad_read_phase_in(rph), .io3_tx_bit_in(txb),
    .data_line_three_out(o), .data_line_three_oe_out(oe), .sck_rise_out(rise),
    .sck_fall_out(fall), .io3_rx_bit_out(rxb), .io3_rx_valid_out(rxv), .so_float_out(flt),
    .pause_active_out(pau), .if_reset_out(ifr), .abort_out(abt));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic wait_pulse(input logic want_fall);
    int i;
    for (i = 0; i < 12; i++) begin
      @(negedge clk);
      if ((want_fall ? fall : rise) === 1'b1) break;
    end
    if (i == 12) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_pulse
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {wph, rph, txb} = 3'h0;
    st2 = 8'h00;
    st3 = 8'h00;
    n_fail = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp({pau, flt, ifr, oe, o, rxb, rxv, abt}, 8'h68);
    repeat (3) @(posedge clk);
    for (r = 0; r < 19; r++) begin
      @(posedge clk);
      st2 <= {6'h00, rows[r][14], 1'b0};
      st3 <= {rows[r][13], 7'h00};
      rph <= rows[r][9];
      txb <= rows[r][8];
      flh_host_i.drive(rows[r][11], rows[r][12], rows[r][10], !rows[r][9]);
      repeat (8) @(negedge clk);
      cmp({3'h0, pau, flt, ifr, oe, o}, rows[r][7:0]);
    end
    // Quad write: one bit per clock rise
    @(posedge clk);
    st2 <= 8'h02;
    rph <= 1'b0;
    wph <= 1'b1;
    for (r = 0; r < 2; r++) begin
      flh_host_i.drive(1'b0, 1'b0, r[0], 1'b1);
      repeat (4) @(posedge clk);
      flh_host_i.drive(1'b1, 1'b0, r[0], 1'b1);
      wait_pulse(1'b0);
      cmp({6'h00, rxv, rxb}, {7'h01, r[0]});
    end
    // Quad read: bit follows each clock fall
    @(posedge clk);
    wph <= 1'b0;
    rph <= 1'b1;
    txb <= 1'b1;
    flh_host_i.drive(1'b0, 1'b0, 1'b1, 1'b0);
    for (r = 0; r < 2; r++) begin
      @(posedge clk);
      txb <= r[0];
      flh_host_i.drive(1'b1, 1'b0, 1'b1, 1'b0);
      repeat (4) @(posedge clk);
      flh_host_i.drive(1'b0, 1'b0, 1'b1, 1'b0);
      wait_pulse(1'b1);
      cmp({6'h00, oe, o}, {7'h01, r[0]});
    end
    // Pin reset while selected: exactly one abort pulse
    @(posedge clk);
    rph <= 1'b0;
    st2 <= 8'h00;
    st3 <= 8'h80;
    flh_host_i.drive(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    flh_host_i.drive(1'b0, 1'b0, 1'b0, 1'b1);
    n_edge = 0;
    repeat (12) begin
      @(negedge clk);
      n_edge += abt;
    end
    cmp(n_edge[7:0], 8'h01);
    cmp({5'h00, ifr, flt, oe}, 8'h06);
    // Pause swallows clock edges but keeps the device selected
    flh_host_i.drive(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    st3 <= 8'h00;
    flh_host_i.drive(1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    flh_host_i.drive(1'b1, 1'b0, 1'b0, 1'b1);
    n_edge = 0;
    repeat (12) begin
      @(negedge clk);
      n_edge += rise;
    end
    cmp(n_edge[7:0], 8'h00);
    cmp({6'h00, pau, ifr}, 8'h02);
    // Reset in mid-run with clock high and line low at the pins
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp({pau, flt, ifr, oe, o, rxb, rxv, abt}, 8'h68);
    repeat (8) @(negedge clk);
    cmp({5'h00, pau, flt, ifr}, 8'h00);
    print_verdict();
  end
endmodule : test_flh_io3_logic
`default_nettype wire
